// File: hdl/eerw_engine.sv
// Transaction engine of a two-wire serial EEPROM target with page buffer and array
// Behaviour
// - Fifteen-bit word address sent as two bytes
// - Byte write: ack every byte, Stop ends
// - Stop after write starts programming; inputs ignored
// - Page write programs up to 64 bytes
// - Page write acks each byte; Stop programs
// - Write increments only in-page address bits
// - In-page address wraps within the same page
// - No acknowledge while programming is in progress
// - Protect input high blocks all array writes
// - Protect sampled at Stop, later changes ignored
// - Protected write acked, no cycle, ready again
// - Direction bit one selects the three reads
// - Address counter holds last access plus one
// - Read counter wraps from top to zero
// - Current read acks, shifts byte at counter
// - Controller no-acknowledge ends read, back standby
// - Controller ack advances address and next byte
// - Array comes up erased, all bytes FF
// - Address byte: type 1010, select, direction
// - Word address bytes: A14..A8, then A7..A0
// - Mismatched address byte unacknowledged, back standby
`timescale 1ns/100ps
`default_nettype none

module eerw_engine #(
    parameter int PROGRAM_CYCLE_TIME_NS = 5000000
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       wp_i,
    input  wire logic [2:0] hw_select_i,
    output logic            sda_o,
    output logic            sda_oe_o
);
    import eerw_pkg::*;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // The commit copies the page during the first PAGE_BYTES cycles of the cycle
    localparam int PROG_RAW    = (PROGRAM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES = (PROG_RAW > PAGE_BYTES) ? PROG_RAW : PAGE_BYTES;
    localparam logic [TMR_W-1:0] PROG_LAST = TMR_W'(PROG_CYCLES - 1);
    localparam logic [TMR_W-1:0] COPY_END  = TMR_W'(PAGE_BYTES);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]        mem  [MEM_DEPTH];
    logic [7:0]        pbuf [PAGE_BYTES];
    logic [7:0]        rd_q;

    eerw_state_t       s;
    eerw_state_t       next_s;
    logic [PIN_N-1:0]  f_next;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_ev;
    logic              stop_ev;
    logic              buf_we;
    logic              mem_we;
    logic              sel_ok;
    logic [PAGE_W-1:0] copy_idx;

    // Erased delivery state
    initial begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] = ERASED_BYTE;
        end
    end

    // ------------------------------------------------------------------
    // Pin filter and bus events
    // ------------------------------------------------------------------
    // A level only counts once the second and third stages agree
    assign f_next   = (s.s2 & ~(s.s2 ^ s.s3)) | (s.f & (s.s2 ^ s.s3));
    assign scl_rise = ~s.f[PIN_SCL] & f_next[PIN_SCL];
    assign scl_fall = s.f[PIN_SCL] & ~f_next[PIN_SCL];
    assign start_ev = s.f[PIN_SCL] & f_next[PIN_SCL] & s.f[PIN_SDA] & ~f_next[PIN_SDA];
    assign stop_ev  = s.f[PIN_SCL] & f_next[PIN_SCL] & ~s.f[PIN_SDA] & f_next[PIN_SDA];
    assign sel_ok   = (s.sr[TYPE_HI:TYPE_LO] == DEV_TYPE) &&
                      (s.sr[SEL_HI:SEL_LO] == s.f[PIN_SEL_HI:PIN_SEL_LO]);
    assign copy_idx = s.tmr[PAGE_W-1:0];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s   = s;
        next_s.s1 = {sda_i, scl_i, wp_i, hw_select_i};
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.f  = f_next;
        buf_we   = 1'b0;
        mem_we   = 1'b0;
        if (s.st == ST_BUSY) begin
            // Bus is deaf here, so polling addresses go unanswered
            next_s.oe  = 1'b0;
            next_s.tmr = s.tmr + 1'b1;
            if (s.tmr < COPY_END && s.mask[copy_idx]) begin
                mem_we = 1'b1;
            end
            if (s.tmr == PROG_LAST) begin
                next_s.st   = ST_IDLE;
                next_s.tmr  = '0;
                next_s.mask = '0;
            end
        end else if (start_ev) begin
            // Repeated start drops any unfinished page
            next_s.st   = ST_DEV;
            next_s.cnt  = '0;
            next_s.ack  = 1'b0;
            next_s.oe   = 1'b0;
            next_s.mask = '0;
        end else if (stop_ev) begin
            next_s.oe  = 1'b0;
            next_s.ack = 1'b0;
            next_s.tmr = '0;
            if (s.st == ST_WDATA && (|s.mask) && !s.f[PIN_WP]) begin
                next_s.st = ST_BUSY;
            end else begin
                next_s.st   = ST_IDLE;
                next_s.mask = '0;
            end
        end else if (scl_rise) begin
            if (s.st != ST_IDLE && s.st != ST_RDATA && !s.ack && s.cnt < BIT_LAST) begin
                next_s.sr  = {s.sr[6:0], f_next[PIN_SDA]};
                next_s.cnt = s.cnt + 1'b1;
            end
            // Controller's answer is taken in the ninth slot only
            if (s.st == ST_RDATA && s.cnt == BIT_ACK) begin
                next_s.mack = f_next[PIN_SDA];
            end
        end else if (scl_fall) begin
            case (s.st)
                ST_DEV, ST_WA_HI, ST_WA_LO, ST_WDATA: begin
                    if (s.ack) begin
                        next_s.ack = 1'b0;
                        next_s.oe  = 1'b0;
                        next_s.cnt = '0;
                        case (s.st)
                            ST_DEV: begin
                                if (s.rw) begin
                                    // Byte at the counter, counter moves past it
                                    next_s.st   = ST_RDATA;
                                    next_s.oe   = ~rd_q[7];
                                    next_s.sr   = {rd_q[6:0], 1'b0};
                                    next_s.cnt  = BIT_FIRST;
                                    next_s.addr = s.addr + 1'b1;
                                end else begin
                                    next_s.st = ST_WA_HI;
                                end
                            end
                            ST_WA_HI: next_s.st = ST_WA_LO;
                            ST_WA_LO: next_s.st = ST_WDATA;
                            default:  next_s.st = s.st;
                        endcase
                    end else if (s.cnt == BIT_LAST) begin
                        next_s.ack = 1'b1;
                        next_s.oe  = 1'b1;
                        case (s.st)
                            ST_DEV: begin
                                next_s.rw = s.sr[RW_BIT];
                                if (!sel_ok) begin
                                    next_s.st  = ST_IDLE;
                                    next_s.ack = 1'b0;
                                    next_s.oe  = 1'b0;
                                end
                            end
                            ST_WA_HI: next_s.addr[ADDR_W-1:8] = s.sr[WA_HI_TOP:0];
                            ST_WA_LO: next_s.addr[7:0] = s.sr;
                            ST_WDATA: begin
                                // Later bytes landing on a used slot overwrite it
                                buf_we = 1'b1;
                                next_s.mask[s.addr[PAGE_W-1:0]] = 1'b1;
                                next_s.addr[PAGE_W-1:0] = s.addr[PAGE_W-1:0] + 1'b1;
                            end
                            default: next_s.st = s.st;
                        endcase
                    end
                end
                ST_RDATA: begin
                    if (s.cnt < BIT_LAST) begin
                        next_s.oe  = ~s.sr[7];
                        next_s.sr  = {s.sr[6:0], 1'b0};
                        next_s.cnt = s.cnt + 1'b1;
                    end else if (s.cnt == BIT_LAST) begin
                        next_s.oe  = 1'b0;
                        next_s.cnt = BIT_ACK;
                    end else if (!s.mack) begin
                        next_s.oe   = ~rd_q[7];
                        next_s.sr   = {rd_q[6:0], 1'b0};
                        next_s.cnt  = BIT_FIRST;
                        next_s.addr = s.addr + 1'b1;
                    end else begin
                        next_s.st  = ST_IDLE;
                        next_s.oe  = 1'b0;
                        next_s.cnt = '0;
                    end
                end
                default: next_s.st = s.st;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '{s1: '1, s2: '1, s3: '1, f: '1, st: ST_IDLE, cnt: '0, sr: '0, ack: 1'b0,
                   mack: 1'b0, rw: 1'b0, addr: '0, mask: '0, tmr: '0, oe: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // No reset on the arrays: contents must survive a logic reset
    always_ff @(posedge sys_clk_i) begin
        if (buf_we) begin
            pbuf[s.addr[PAGE_W-1:0]] <= s.sr;
        end
        if (mem_we) begin
            mem[{s.addr[ADDR_W-1:PAGE_W], copy_idx}] <= pbuf[copy_idx];
        end
        rd_q <= mem[s.addr];
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = s.oe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_busy_silent;
        s.st == ST_BUSY |-> !sda_oe_o;
    endproperty
    a_busy_silent: assert property (p_busy_silent) else $error("drive during programming");

    property p_busy_holds;
        (s.st == ST_BUSY && s.tmr != PROG_LAST) |=> s.st == ST_BUSY;
    endproperty
    a_busy_holds: assert property (p_busy_holds) else $error("programming ended early");

    property p_busy_length;
        $fell(s.st == ST_BUSY) |-> $past(s.tmr) == PROG_LAST;
    endproperty
    a_busy_length: assert property (p_busy_length) else $error("wrong programming length");

    property p_wp_blocks;
        (stop_ev && s.st == ST_WDATA && s.f[PIN_WP]) |=> s.st == ST_IDLE ##1 s.st != ST_BUSY;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("protected write programmed");

    property p_write_commit;
        (stop_ev && s.st == ST_WDATA && (|s.mask) && !s.f[PIN_WP]) |=> s.st == ST_BUSY;
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("stop did not program");

    property p_mem_we_busy;
        mem_we |-> s.st == ST_BUSY && s.tmr < COPY_END;
    endproperty
    a_mem_we_busy: assert property (p_mem_we_busy) else $error("array written outside cycle");

    property p_page_incr;
        (scl_fall && s.st == ST_WDATA && !s.ack && s.cnt == BIT_LAST) |=>
            s.addr[ADDR_W-1:PAGE_W] == $past(s.addr[ADDR_W-1:PAGE_W]) &&
            s.addr[PAGE_W-1:0] == $past(s.addr[PAGE_W-1:0]) + 1'b1 && sda_oe_o;
    endproperty
    a_page_incr: assert property (p_page_incr) else $error("page address step wrong");

    property p_read_incr;
        (scl_fall && s.st == ST_RDATA && s.cnt == BIT_ACK && !s.mack) |=>
            s.addr == $past(s.addr) + 1'b1 && s.cnt == BIT_FIRST;
    endproperty
    a_read_incr: assert property (p_read_incr) else $error("read address step wrong");

    property p_read_nack;
        (scl_fall && s.st == ST_RDATA && s.cnt == BIT_ACK && s.mack) |=>
            s.st == ST_IDLE && !sda_oe_o;
    endproperty
    a_read_nack: assert property (p_read_nack) else $error("read kept going after nack");

    property p_dev_mismatch;
        (scl_fall && s.st == ST_DEV && !s.ack && s.cnt == BIT_LAST && !sel_ok) |=>
            s.st == ST_IDLE && !sda_oe_o;
    endproperty
    a_dev_mismatch: assert property (p_dev_mismatch) else $error("foreign address acknowledged");

    property p_addr_ack;
        (scl_fall && (s.st == ST_WA_HI || s.st == ST_WA_LO) && !s.ack && s.cnt == BIT_LAST) |=>
            sda_oe_o && s.ack;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("word address not acknowledged");

    property p_ack_release;
        (scl_fall && s.ack && !(s.st == ST_DEV && s.rw)) |=> !sda_oe_o;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("acknowledge held past its slot");

    property p_read_first;
        (scl_fall && s.st == ST_DEV && s.ack && s.rw) |=>
            s.st == ST_RDATA && sda_oe_o == !$past(rd_q[7]) && s.addr == $past(s.addr) + 1'b1;
    endproperty
    a_read_first: assert property (p_read_first) else $error("current read did not start");

    property p_read_release;
        (scl_fall && s.st == ST_RDATA && s.cnt == BIT_LAST) |=> !sda_oe_o && s.cnt == BIT_ACK;
    endproperty
    a_read_release: assert property (p_read_release) else $error("data line held in answer slot");

    property p_wa_load;
        (scl_fall && s.st == ST_WA_LO && !s.ack && s.cnt == BIT_LAST) |=> s.addr[7:0] == $past(s.sr);
    endproperty
    a_wa_load: assert property (p_wa_load) else $error("low word address not loaded");

    property p_idle_quiet;
        s.st == ST_IDLE |-> !sda_oe_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while in standby");

    property p_buf_only_data;
        buf_we |-> s.st == ST_WDATA && !s.ack;
    endproperty
    a_buf_only_data: assert property (p_buf_only_data) else $error("page buffer written outside data");

    c_byte_write: cover property (s.st == ST_WDATA && stop_ev ##1 s.st == ST_BUSY);
    c_seq_read:   cover property (s.st == ST_RDATA && s.cnt == BIT_ACK && !s.mack && scl_fall);
    c_wp_refuse:  cover property (stop_ev && s.st == ST_WDATA && (|s.mask) && s.f[PIN_WP]);
    c_dev_nack:   cover property (scl_fall && s.st == ST_DEV && s.cnt == BIT_LAST && !sel_ok);
    c_page_wrap:  cover property (buf_we && s.addr[PAGE_W-1:0] == '1);

endmodule // eerw_engine

`default_nettype wire

// File: hdl/eerw_pkg.sv
// Constants, state encodings and state record of the serial EEPROM transaction engine
package eerw_pkg;

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 15;
    localparam int          PAGE_W      = 6;
    localparam int          ROW_W       = ADDR_W - PAGE_W;
    localparam int          PAGE_BYTES  = 1 << PAGE_W;
    localparam int          MEM_DEPTH   = 1 << ADDR_W;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    // ------------------------------------------------------------------
    // Target address byte layout
    // ------------------------------------------------------------------
    localparam logic [3:0]  DEV_TYPE    = 4'hA;
    localparam int          TYPE_HI     = 7;
    localparam int          TYPE_LO     = 4;
    localparam int          SEL_HI      = 3;
    localparam int          SEL_LO      = 1;
    localparam int          RW_BIT      = 0;
    localparam int          WA_HI_TOP   = 6;

    // ------------------------------------------------------------------
    // Bit slots in a byte frame
    // ------------------------------------------------------------------
    localparam logic [3:0]  BIT_FIRST   = 4'h1;
    localparam logic [3:0]  BIT_LAST    = 4'h8;
    localparam logic [3:0]  BIT_ACK     = 4'h9;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          TMR_W         = 26;

    // ------------------------------------------------------------------
    // Synchronised pin vector positions
    // ------------------------------------------------------------------
    localparam int          PIN_N       = 6;
    localparam int          PIN_SEL_LO  = 0;
    localparam int          PIN_SEL_HI  = 2;
    localparam int          PIN_WP      = 3;
    localparam int          PIN_SCL     = 4;
    localparam int          PIN_SDA     = 5;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WA_HI,
        ST_WA_LO,
        ST_WDATA,
        ST_RDATA,
        ST_BUSY
    } eerw_fsm_t;

    typedef struct packed {
        logic [PIN_N-1:0]      s1;
        logic [PIN_N-1:0]      s2;
        logic [PIN_N-1:0]      s3;
        logic [PIN_N-1:0]      f;
        eerw_fsm_t             st;
        logic [3:0]            cnt;
        logic [7:0]            sr;
        logic                  ack;
        logic                  mack;
        logic                  rw;
        logic [ADDR_W-1:0]     addr;
        logic [PAGE_BYTES-1:0] mask;
        logic [TMR_W-1:0]      tmr;
        logic                  oe;
    } eerw_state_t;

endpackage

// File: sim/eerw_engine_tb.sv
// Self-checking testbench of the serial EEPROM transaction engine
`timescale 1ns/100ps
`default_nettype none

module eerw_engine_tb;
    import eerw_pkg::*;

    localparam logic [2:0] SEL  = 3'h5;
    localparam logic [7:0] DEVW = 8'hAA;
    localparam logic [7:0] DEVR = 8'hAB;

    logic       sys_clk = 1'b0;
    logic       rst_b   = 1'b0;
    logic       wp      = 1'b0;
    logic       scl;
    logic       pull;
    logic       sda_o;
    logic       sda_oe;
    wire logic  sda_line;
    int         n_fail     = 0;
    int         n_compared = 0;

    // Open drain wire with pull-up
    assign sda_line = !pull && !(sda_oe && !sda_o);

    always #5 sys_clk = ~sys_clk;

    eerw_master m (
        .sys_clk_i  (sys_clk),
        .sda_i      (sda_line),
        .scl_o      (scl),
        .sda_pull_o (pull)
    );

    // Short programming time keeps polling loops brief: 500 cycles
    eerw_engine #(.PROGRAM_CYCLE_TIME_NS(5000)) dut (
        .sys_clk_i   (sys_clk),
        .rst_b_i     (rst_b),
        .scl_i       (scl),
        .sda_i       (sda_line),
        .wp_i        (wp),
        .hw_select_i (SEL),
        .sda_o       (sda_o),
        .sda_oe_o    (sda_oe)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic send(input logic [7:0] d);
        logic k;
        m.wr_byte(d, k);
        chk({7'h00, k}, 8'h01);
    endtask

    // Bit 7 of the high word byte always set: it must be ignored
    task automatic dummy(input logic [14:0] a);
        m.start();
        send(DEVW);
        send({1'b1, a[14:8]});
        send(a[7:0]);
    endtask

    task automatic read_at(input logic [14:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] d;
        logic       r;
        dummy(a);
        m.start();
        send(DEVR);
        m.rd_byte(1'b1, d);
        chk(d, e0);
        m.rd_byte(1'b0, d);
        chk(d, e1);
        m.bit_io(1'b1, r);
        chk({7'h00, r}, 8'h01);
        m.stop();
    endtask

    task automatic poll(output int n);
        logic k;
        n = 0;
        k = 1'b0;
        while (!k && n < 8) begin
            n++;
            m.start();
            m.wr_byte(DEVW, k);
            m.stop();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_erased();
        read_at(15'h1234, ERASED_BYTE, ERASED_BYTE);
    endtask

    task automatic t_byte_write();
        int n;
        dummy(15'h0000);
        send(8'h5A);
        m.stop();
        wp <= 1'b1;
        poll(n);
        // A poll lasts about 1.5 us against a 5 us cycle: the fifth one answers
        chk({7'h00, n >= 4 && n <= 6}, 8'h01);
        wp <= 1'b0;
        read_at(15'h0000, 8'h5A, ERASED_BYTE);
    endtask

    task automatic t_page_wrap();
        int         n;
        logic [7:0] d;
        dummy(15'h017E);
        send(8'h11);
        send(8'h22);
        send(8'h33);
        m.stop();
        poll(n);
        m.start();
        send(DEVR);
        m.rd_byte(1'b0, d);
        chk(d, ERASED_BYTE);
        m.stop();
        read_at(15'h017E, 8'h11, 8'h22);
        read_at(15'h0140, 8'h33, ERASED_BYTE);
    endtask

    task automatic t_protect();
        int n;
        wp <= 1'b1;
        dummy(15'h0141);
        send(8'h77);
        m.stop();
        wp <= 1'b0;
        poll(n);
        chk({7'h00, n == 1}, 8'h01);
        read_at(15'h0141, ERASED_BYTE, ERASED_BYTE);
    endtask

    task automatic t_top_wrap();
        read_at(15'h7FFF, ERASED_BYTE, 8'h5A);
    endtask

    task automatic t_bad_addr();
        logic       k;
        logic [7:0] d;
        m.start();
        m.wr_byte(8'hA8, k);
        chk({7'h00, k}, 8'h00);
        m.start();
        m.wr_byte(8'hBA, k);
        chk({7'h00, k}, 8'h00);
        m.start();
        send(DEVR);
        m.rd_byte(1'b0, d);
        chk(d, ERASED_BYTE);
        m.stop();
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge sys_clk);
        t_erased();
        t_byte_write();
        t_page_wrap();
        t_protect();
        t_top_wrap();
        t_bad_addr();
        finish_test();
    end

    // Scenarios need roughly 9k cycles
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule // eerw_engine_tb

`default_nettype wire

// File: sim/eerw_master.sv
// Two-wire bus controller model that drives the engine's bus pins
`timescale 1ns/100ps
`default_nettype none

module eerw_master (
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    // ------------------------------------------------------------------
    // Bus idle: clock high, data released to the pull-up
    // ------------------------------------------------------------------
    logic stretch = 1'b0;

    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // Works from idle and as repeated Start; first wait covers device release lag
    task automatic start();
        sda_pull_o <= 1'b0;
        tick(6);
        scl_o <= 1'b1;
        tick(6);
        sda_pull_o <= 1'b1;
        tick(6);
        scl_o <= 1'b0;
    endtask

    task automatic stop();
        sda_pull_o <= 1'b1;
        tick(6);
        scl_o <= 1'b1;
        tick(6);
        sda_pull_o <= 1'b0;
        tick(6);
    endtask

    // Low half alternates 60 and 70 ns so the period averages 125 ns
    // Data moves one cycle after the fall, keeping a hold time
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_pull_o <= !b;
        tick(5 + int'(stretch));
        stretch = !stretch;
        scl_o <= 1'b1;
        tick(6);
        r = sda_i;
        scl_o <= 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!more, r);
    endtask
endmodule // eerw_master

`default_nettype wire
